// ===== proc_element.sv
/*
  one processing element: register file, alu, multiplier and shifter.
  assumes the sequencer holds instruction fields steady for the issuing cycle.
*/
`timescale 1ns/1ps
module proc_element
  import simd_pkg::*;
#(
  parameter int REGS = NUM_REGS
) (
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  // instruction
  input  wire logic                 i_active,
  input  wire logic                 i_bank_sel,
  input  wire unit_e                i_unit,
  input  wire alu_op_e              i_alu_op,
  input  wire fmt_e                 i_fmt,
  input  wire logic [REG_IDX_W-1:0] i_src_a,
  input  wire logic [REG_IDX_W-1:0] i_src_b,
  input  wire logic [REG_IDX_W-1:0] i_dst_alu,
  input  wire logic [REG_IDX_W-1:0] i_dst_mul,
  input  wire logic signed [5:0]    i_shift,
  // bus load ports, one per data bus
  input  wire logic                 i_ld0_en,
  input  wire logic [REG_IDX_W-1:0] i_ld0_idx,
  input  wire logic [DATA_W-1:0]    i_ld0_data,
  input  wire logic                 i_ld1_en,
  input  wire logic [REG_IDX_W-1:0] i_ld1_idx,
  input  wire logic [DATA_W-1:0]    i_ld1_data,
  input  wire logic [REG_IDX_W-1:0] i_st_idx,
  // results
  output logic      [DATA_W-1:0]    o_st_data,
  output logic      [DATA_W-1:0]    o_result
);
  if (REGS != 2 * (1 << REG_IDX_W)) begin : g_bad_regs
    $error("proc_element needs two banks of sixteen");
  end

  logic [DATA_W-1:0] regs [REGS];
  logic [DATA_W-1:0] next_alu, next_mul, a, b;
  logic [DATA_W-1:0] st_data, result;
  logic [REG_IDX_W:0] base;

  function automatic logic [DATA_W-1:0] fmul(input fmt_e f, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] y);
    logic [63:0] p;
    logic [47:0] m;
    logic [9:0]  e;
    p = '0;
    m = '0;
    e = '0;
    if (f == FMT_FIXED) begin
      // fixed words sit in the top 32 bits like every load, so take and return them there
      p = $signed(x[DATA_W-1:DATA_W-WORD_W]) * $signed(y[DATA_W-1:DATA_W-WORD_W]);
      fmul = {p[WORD_W-1:0], 8'h00};
    end else begin
      // float: sign, 8-bit exponent, 31-bit mantissa field; single uses top 23 bits
      m = {1'b1, x[30:8]} * {1'b1, y[30:8]};
      e = {2'b00, x[38:31]} + {2'b00, y[38:31]} - {2'b00, FLT_BIAS};
      if (m[47]) begin
        m = m >> 1;
        e = e + 10'h001;
      end
      fmul = {x[39] ^ y[39], e[7:0], m[45:23], (f == FMT_EXT) ? 8'h00 : 8'h00};
    end
  endfunction

  always_comb begin
    base = {i_bank_sel, {REG_IDX_W{1'b0}}};
    a = regs[base + {1'b0, i_src_a}];
    b = regs[base + {1'b0, i_src_b}];
    case (i_alu_op)
      ALU_ADD: next_alu = a + b;
      ALU_SUB: next_alu = a - b;
      ALU_AND: next_alu = a & b;
      ALU_OR:  next_alu = a | b;
      ALU_XOR: next_alu = a ^ b;
      default: next_alu = a;
    endcase
    if (i_fmt == FMT_SINGLE) next_alu[7:0] = 8'h00;
    next_mul = fmul(i_fmt, a, b);
    if (i_unit == UNIT_SHIFT) begin
      next_alu = (i_shift >= 0) ? (a << i_shift) : (a >> (-i_shift));
    end
  end

  // every unit completes in the issuing cycle; multi writes alu and mul together
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int k = 0; k < REGS; k++) regs[k] <= '0;
      st_data <= '0;
      result  <= '0;
    end else begin
      if (i_ld0_en) regs[base + {1'b0, i_ld0_idx}] <= i_ld0_data;
      if (i_ld1_en) regs[base + {1'b0, i_ld1_idx}] <= i_ld1_data;
      if (i_active) begin
        if (i_unit != UNIT_MUL) regs[base + {1'b0, i_dst_alu}] <= next_alu;
        if (i_unit == UNIT_MUL || i_unit == UNIT_MULTI) regs[base + {1'b0, i_dst_mul}] <= next_mul;
        result <= (i_unit == UNIT_MUL) ? next_mul : next_alu;
      end
      st_data <= regs[base + {1'b0, i_st_idx}];
    end
  end

  assign o_st_data = st_data;
  assign o_result  = result;
endmodule

// ===== prog_mem_model.sv
/* program-memory model answering instruction fetches.
   assumes fetches are taken on rising edges of i_core_clk. */
`timescale 1ns/1ps
module prog_mem_model
  import simd_pkg::*;
(
  // fetch request
  input  wire logic               i_core_clk,
  input  wire logic               i_fetch,
  input  wire logic [PADDR_W-1:0] i_fetch_addr,
  // instruction word
  output logic      [INSTR_W-1:0] o_pm_instr
);
  logic               shown = 1'b0;
  logic [INSTR_W-1:0] word  = '0;
  always @(posedge i_core_clk) begin
    shown <= i_fetch;
    if (i_fetch) word <= {i_fetch_addr, ~i_fetch_addr};
  end
  // a free fetch is served in its own cycle, a stalled one in the cycle after;
  // otherwise the bus shows the inverse so a stale word never looks fetched
  assign o_pm_instr = i_fetch ? {i_fetch_addr, ~i_fetch_addr} : shown ? word : ~word;
endmodule

// ===== simd_datapath.sv
/*
  dual-element datapath with selective instruction cache and dual-bus operand paths.
  assumes program memory shows a free fetch's word in the fetching cycle and a stalled one in the next.
*/
`timescale 1ns/1ps
module simd_datapath
  import simd_pkg::*;
(
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  // mode
  input  wire logic                 i_mode_we,
  input  wire logic [MODE_W-1:0]    i_mode_wdata,
  // instruction fields from the sequencer
  input  wire logic                 i_issue,
  input  wire unit_e                i_unit,
  input  wire alu_op_e              i_alu_op,
  input  wire fmt_e                 i_fmt,
  input  wire logic                 i_bank_sel,
  input  wire logic [REG_IDX_W-1:0] i_src_a,
  input  wire logic [REG_IDX_W-1:0] i_src_b,
  input  wire logic [REG_IDX_W-1:0] i_dst_alu,
  input  wire logic [REG_IDX_W-1:0] i_dst_mul,
  input  wire logic signed [5:0]    i_shift,
  // address generator transfers
  input  wire logic                 i_dm_ld,
  input  wire logic [REG_IDX_W-1:0] i_dm_idx,
  input  wire logic [2*WORD_W-1:0]  i_dm_rdata,
  input  wire logic                 i_pm_ld,
  input  wire logic [REG_IDX_W-1:0] i_pm_idx,
  input  wire logic [2*WORD_W-1:0]  i_pm_rdata,
  input  wire logic [REG_IDX_W-1:0] i_st_idx,
  // instruction fetch
  input  wire logic                 i_fetch,
  input  wire logic [PADDR_W-1:0]   i_fetch_addr,
  input  wire logic                 i_pm_data_busy,
  input  wire logic [INSTR_W-1:0]   i_pm_instr,
  // outputs
  output logic [MODE_W-1:0]         o_mode,
  output logic [2*WORD_W-1:0]       o_dm_wdata,
  output logic [DATA_W-1:0]         o_result_x,
  output logic [DATA_W-1:0]         o_result_y,
  output logic                      o_instr_valid,
  output logic [INSTR_W-1:0]        o_instr,
  output logic                      o_stall
);
  localparam int LINES = 1 << CACHE_IDX_W;

  logic [MODE_W-1:0] mode, next_mode;
  logic              dual;
  logic [DATA_W-1:0] st_x, st_y, res_x, res_y;
  logic [2*WORD_W-1:0] dm_wdata, next_dm_wdata;

  always_comb begin
    next_mode = i_mode_we ? i_mode_wdata : mode;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) mode <= '0;
    else mode <= next_mode;
  end
  assign dual   = mode[SEC_ENABLE_BIT];
  assign o_mode = mode;

  // both elements see the same instruction fields; data differs and the second issues and loads only when dual
  proc_element u_first (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (i_issue),
    .i_bank_sel (i_bank_sel),
    .i_unit     (i_unit),
    .i_alu_op   (i_alu_op),
    .i_fmt      (i_fmt),
    .i_src_a    (i_src_a),
    .i_src_b    (i_src_b),
    .i_dst_alu  (i_dst_alu),
    .i_dst_mul  (i_dst_mul),
    .i_shift    (i_shift),
    .i_ld0_en   (i_dm_ld),
    .i_ld0_idx  (i_dm_idx),
    .i_ld0_data ({i_dm_rdata[WORD_W-1:0], 8'h00}),
    .i_ld1_en   (i_pm_ld),
    .i_ld1_idx  (i_pm_idx),
    .i_ld1_data ({i_pm_rdata[WORD_W-1:0], 8'h00}),
    .i_st_idx   (i_st_idx),
    .o_st_data  (st_x),
    .o_result   (res_x)
  );

  proc_element u_second (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (i_issue & dual),
    .i_bank_sel (i_bank_sel),
    .i_unit     (i_unit),
    .i_alu_op   (i_alu_op),
    .i_fmt      (i_fmt),
    .i_src_a    (i_src_a),
    .i_src_b    (i_src_b),
    .i_dst_alu  (i_dst_alu),
    .i_dst_mul  (i_dst_mul),
    .i_shift    (i_shift),
    .i_ld0_en   (i_dm_ld & dual),
    .i_ld0_idx  (i_dm_idx),
    .i_ld0_data ({i_dm_rdata[2*WORD_W-1:WORD_W], 8'h00}),
    .i_ld1_en   (i_pm_ld & dual),
    .i_ld1_idx  (i_pm_idx),
    .i_ld1_data ({i_pm_rdata[2*WORD_W-1:WORD_W], 8'h00}),
    .i_st_idx   (i_st_idx),
    .o_st_data  (st_y),
    .o_result   (res_y)
  );

  // two 32-bit values per bus each cycle: four transfers in all
  always_comb begin
    next_dm_wdata = {dual ? st_y[DATA_W-1:DATA_W-WORD_W] : {WORD_W{1'b0}}, st_x[DATA_W-1:DATA_W-WORD_W]};
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) dm_wdata <= '0;
    else dm_wdata <= next_dm_wdata;
  end
  assign o_dm_wdata = dm_wdata;
  assign o_result_x = res_x;
  assign o_result_y = res_y;

  // selective cache: only fetches that collide with program-bus data are kept
  logic                          vld [LINES];
  logic [PADDR_W-CACHE_IDX_W-1:0] tag [LINES];
  logic [INSTR_W-1:0]            line [LINES];
  logic [CACHE_IDX_W-1:0]        idx;
  logic                          hit, conflict;
  fetch_state_e                  state, next_state;
  logic                          next_valid, next_stall;
  logic [INSTR_W-1:0]            next_instr;
  logic                          instr_valid, stall;
  logic [INSTR_W-1:0]            instr;
  logic [PADDR_W-1:0]            miss_addr, next_miss_addr;

  assign idx      = i_fetch_addr[CACHE_IDX_W-1:0];
  assign hit      = vld[idx] && tag[idx] == i_fetch_addr[PADDR_W-1:CACHE_IDX_W];
  assign conflict = i_fetch & i_pm_data_busy;

  always_comb begin
    next_state     = state;
    next_valid     = 1'b0;
    next_instr     = instr;
    next_stall     = 1'b0;
    next_miss_addr = miss_addr;
    case (state)
      FETCH_IDLE: next_state = FETCH_RUN;
      FETCH_RUN: begin
        if (i_fetch) begin
          if (conflict && hit) begin
            next_valid = 1'b1;
            next_instr = line[idx];
          end else if (conflict) begin
            next_state     = FETCH_STALL;
            next_stall     = 1'b1;
            next_miss_addr = i_fetch_addr;
          end else begin
            next_valid = 1'b1;
            next_instr = i_pm_instr;
          end
        end
      end
      FETCH_STALL: begin
        next_state = FETCH_RUN;
        next_valid = 1'b1;
        next_instr = i_pm_instr;
      end
      default: next_state = FETCH_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state       <= FETCH_IDLE;
      instr_valid <= 1'b0;
      instr       <= '0;
      stall       <= 1'b0;
      miss_addr   <= '0;
      for (int k = 0; k < LINES; k++) begin
        vld[k]  <= 1'b0;
        tag[k]  <= '0;
        line[k] <= '0;
      end
    end else begin
      state       <= next_state;
      instr_valid <= next_valid;
      instr       <= next_instr;
      stall       <= next_stall;
      miss_addr   <= next_miss_addr;
      if (state == FETCH_STALL) begin
        vld[miss_addr[CACHE_IDX_W-1:0]]  <= 1'b1;
        tag[miss_addr[CACHE_IDX_W-1:0]]  <= miss_addr[PADDR_W-1:CACHE_IDX_W];
        line[miss_addr[CACHE_IDX_W-1:0]] <= i_pm_instr;
      end
    end
  end

  assign o_instr_valid = instr_valid;
  assign o_instr       = instr;
  assign o_stall       = stall;
endmodule

// ===== simd_datapath_test.sv
/* self-checking bench for simd_datapath with a program-memory model.
   assumes a 200 MHz core clock and synchronous active-high reset. */
`timescale 1ns/1ps
module simd_datapath_test
  import simd_pkg::*;
;
  typedef struct {
    alu_op_e     op;
    logic [31:0] xa, xb, ya, yb, xr, yr;
  } row_s;
  logic                 i_core_clk, i_rst, i_mode_we, i_issue, i_bank_sel, i_dm_ld, i_pm_ld;
  logic                 i_fetch, i_pm_data_busy, o_instr_valid, o_stall;
  logic [MODE_W-1:0]    i_mode_wdata, o_mode;
  unit_e                i_unit;
  alu_op_e              i_alu_op;
  fmt_e                 i_fmt;
  logic [REG_IDX_W-1:0] i_src_a, i_src_b, i_dst_alu, i_dst_mul, i_dm_idx, i_pm_idx, i_st_idx;
  logic signed [5:0]    i_shift;
  logic [2*WORD_W-1:0]  i_dm_rdata, i_pm_rdata, o_dm_wdata;
  logic [PADDR_W-1:0]   i_fetch_addr;
  logic [INSTR_W-1:0]   i_pm_instr, o_instr;
  logic [DATA_W-1:0]    o_result_x, o_result_y;
  int                   n_fail = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;
  row_s                 r;
  row_s rows[6] = '{
    '{ALU_PASS, 32'h1234, 32'h5, 32'hABC, 32'h1, 32'h1234, 32'hABC},
    '{ALU_ADD, 32'h1000, 32'h234, 32'hFF, 32'h1, 32'h1234, 32'h100},
    '{ALU_SUB, 32'h5000, 32'h1000, 32'h3, 32'h1, 32'h4000, 32'h2},
    '{ALU_AND, 32'hF0F0, 32'hFF00, 32'h1234, 32'hFF, 32'hF000, 32'h34},
    '{ALU_OR, 32'hF000, 32'hF, 32'h1200, 32'h34, 32'hF00F, 32'h1234},
    '{ALU_XOR, 32'hFFFF, 32'hF0F, 32'hAA, 32'h55, 32'hF0F0, 32'hFF}};
  simd_datapath dut (.i_core_clk, .i_rst, .i_mode_we, .i_mode_wdata, .i_issue, .i_unit, .i_alu_op,
    .i_fmt, .i_bank_sel, .i_src_a, .i_src_b, .i_dst_alu, .i_dst_mul, .i_shift, .i_dm_ld, .i_dm_idx,
    .i_dm_rdata, .i_pm_ld, .i_pm_idx, .i_pm_rdata, .i_st_idx, .i_fetch, .i_fetch_addr,
    .i_pm_data_busy, .i_pm_instr, .o_mode, .o_dm_wdata, .o_result_x, .o_result_y,
    .o_instr_valid, .o_instr, .o_stall);
  prog_mem_model mem (.i_core_clk, .i_fetch, .i_fetch_addr, .o_pm_instr(i_pm_instr));
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task step;
    @(posedge i_core_clk);
    #1;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // the gap cycle after each fetch keeps the no-fetch-after-stall spacing
  task fet(input logic [PADDR_W-1:0] a, input logic busy, input logic stl);
    i_fetch = 1'b1;
    i_fetch_addr = a;
    i_pm_data_busy = busy;
    step;
    i_fetch = 1'b0;
    i_pm_data_busy = 1'b0;
    chk(64'(o_stall), 64'(stl));
    if (stl) step;
    chk(64'(o_instr_valid), 64'h1);
    step;
  endtask
  task load(input logic [63:0] d, input logic [63:0] p);
    i_dm_ld = 1'b1;
    i_dm_rdata = d;
    i_pm_ld = 1'b1;
    i_pm_rdata = p;
    step;
    i_dm_ld = 1'b0;
    i_pm_ld = 1'b0;
    i_issue = 1'b1;
    step;
    i_issue = 1'b0;
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    i_rst = 1'b1;
    i_mode_we = 1'b0;
    i_mode_wdata = '0;
    i_issue = 1'b0;
    i_unit = UNIT_ALU;
    i_alu_op = ALU_PASS;
    i_fmt = FMT_FIXED;
    i_bank_sel = 1'b0;
    i_src_a = 4'h1;
    i_src_b = 4'h2;
    i_dst_alu = 4'h3;
    i_dst_mul = 4'h4;
    i_shift = 6'sh0;
    i_dm_ld = 1'b0;
    i_dm_idx = 4'h1;
    i_dm_rdata = '0;
    i_pm_ld = 1'b0;
    i_pm_idx = 4'h2;
    i_pm_rdata = '0;
    i_st_idx = 4'h3;
    i_fetch = 1'b0;
    i_fetch_addr = '0;
    i_pm_data_busy = 1'b0;
    repeat (5) step;
    i_rst = 1'b0;
    step;
    i_mode_wdata = MODE_W'(1) << SEC_ENABLE_BIT;
    i_mode_we = 1'b1;
    step;
    i_mode_we = 1'b0;
    chk(64'(o_mode), 64'(i_mode_wdata));
    foreach (rows[k]) begin
      r = rows[k];
      i_alu_op = r.op;
      load({r.ya, r.xa}, {r.yb, r.xb});
      chk(64'(o_result_x), 64'({r.xr, 8'h00}));
      chk(64'(o_result_y), 64'({r.yr, 8'h00}));
      // store data passes the register read and the bus register: two edges
      repeat (2) step;
      chk(o_dm_wdata, {r.yr, r.xr});
    end
    i_unit = UNIT_MULTI;
    i_alu_op = ALU_ADD;
    i_st_idx = 4'h4;
    load({32'h3, 32'h2}, {32'h5, 32'h7});
    chk(64'(o_result_x), 64'h900);
    chk(64'(o_result_y), 64'h800);
    repeat (2) step;
    chk(o_dm_wdata, {32'hF, 32'hE});
    i_unit = UNIT_MUL;
    i_fmt = FMT_SINGLE;
    load({32'h3FC00000, 32'h40000000}, {32'h40000000, 32'h40400000});
    chk(64'(o_result_x), 64'h40C0000000);
    chk(64'(o_result_y), 64'h4040000000);
    i_fmt = FMT_FIXED;
    i_unit = UNIT_ALU;
    i_alu_op = ALU_PASS;
    i_bank_sel = 1'b1;
    load({32'h77, 32'h66}, 64'h0);
    chk(64'(o_result_x), 64'h6600);
    chk(64'(o_result_y), 64'h7700);
    i_bank_sel = 1'b0;
    i_unit = UNIT_SHIFT;
    i_shift = -6'sd4;
    i_issue = 1'b1;
    step;
    i_issue = 1'b0;
    chk(64'(o_result_x), 64'h0400000000);
    chk(64'(o_result_y), 64'h03FC000000);
    i_unit = UNIT_ALU;
    i_shift = 6'sh0;
    i_mode_wdata = '0;
    i_mode_we = 1'b1;
    step;
    i_mode_we = 1'b0;
    i_alu_op = ALU_ADD;
    i_src_a = 4'h2;
    i_src_b = 4'h1;
    i_dst_alu = 4'h5;
    i_st_idx = 4'h5;
    load(64'h0000AAAA_00000001, 64'h0000BBBB_00000002);
    chk(64'(o_result_x), 64'h300);
    chk(64'(o_result_y), 64'h03FC000000);
    repeat (2) step;
    chk(o_dm_wdata, 64'h3);
    fet(24'h000123, 1'b1, 1'b1);
    chk(64'(o_instr), 64'({24'h000123, ~24'h000123}));
    fet(24'h000123, 1'b1, 1'b0);
    chk(64'(o_instr), 64'({24'h000123, ~24'h000123}));
    fet(24'h000045, 1'b0, 1'b0);
    chk(64'(o_instr), 64'({24'h000045, ~24'h000045}));
    fet(24'h000045, 1'b1, 1'b1);
    i_rst = 1'b1;
    step;
    i_rst = 1'b0;
    chk(64'(o_result_y), 64'h0);
    chk(64'(o_mode), 64'h0);
    chk(64'(o_result_x), 64'h0);
    chk(o_dm_wdata, 64'h0);
    chk(64'({o_instr, o_instr_valid, o_stall}), 64'h0);
    // reset empties the cache, so the same conflicting fetch must miss again
    step;
    fet(24'h000045, 1'b1, 1'b1);
    chk(64'(o_instr), 64'({24'h000045, ~24'h000045}));
    wrap_up;
  end
endmodule

// ===== simd_pkg.sv
/*
  constants and types shared by the dual-element datapath.
  assumes a single 200 MHz core clock and a synchronous active-high reset.
*/
package simd_pkg;
  localparam int DATA_W     = 40;
  localparam int WORD_W     = 32;
  localparam int INSTR_W    = 48;
  localparam int PADDR_W    = 24;
  localparam int REG_IDX_W  = 4;
  localparam int NUM_REGS   = 32;
  localparam int CACHE_IDX_W = 5;
  localparam int MODE_W     = 32;
  localparam int SEC_ENABLE_BIT = 21;
  localparam logic [7:0] FLT_BIAS = 8'h7F;

  typedef enum logic [1:0] {
    FMT_FIXED  = 2'h0,
    FMT_SINGLE = 2'h1,
    FMT_EXT    = 2'h2
  } fmt_e;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_ADD  = 3'h1,
    ALU_SUB  = 3'h2,
    ALU_AND  = 3'h3,
    ALU_OR   = 3'h4,
    ALU_XOR  = 3'h5
  } alu_op_e;

  typedef enum logic [1:0] {
    UNIT_ALU   = 2'h0,
    UNIT_MUL   = 2'h1,
    UNIT_SHIFT = 2'h2,
    UNIT_MULTI = 2'h3
  } unit_e;

  typedef enum logic [1:0] {
    FETCH_IDLE  = 2'h0,
    FETCH_RUN   = 2'h1,
    FETCH_STALL = 2'h3
  } fetch_state_e;
endpackage

// ===== simd_properties.sv
/* port checker for simd_datapath.
   assumes it is bound to the top module and shares its clock. */
`timescale 1ns/1ps
module simd_properties
  import simd_pkg::*;
(
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  input wire logic                i_mode_we,
  input wire logic [MODE_W-1:0]   i_mode_wdata,
  input wire logic                i_issue,
  input wire logic                i_fetch,
  input wire logic                i_pm_data_busy,
  input wire logic [MODE_W-1:0]   o_mode,
  input wire logic [2*WORD_W-1:0] o_dm_wdata,
  input wire logic [DATA_W-1:0]   o_result_x,
  input wire logic [DATA_W-1:0]   o_result_y,
  input wire logic                o_instr_valid,
  input wire logic                o_stall
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence conflict_s;
    i_fetch && i_pm_data_busy;
  endsequence
  sequence miss_s;
    conflict_s ##1 o_stall;
  endsequence
  wire single = !o_mode[SEC_ENABLE_BIT] && !i_mode_we;
  mode_load_a: assert property (i_mode_we |=> o_mode == $past(i_mode_wdata))
    else $error("mode register not loaded");
  second_idle_a: assert property (single |=> $stable(o_result_y))
    else $error("second element ran while disabled");
  store_high_a: assert property (single |=> o_dm_wdata[63:32] == 32'h0)
    else $error("high store word not zero");
  result_hold_a: assert property (!i_issue |=> $stable(o_result_x))
    else $error("result moved without issue");
  stall_cause_a: assert property (o_stall |-> $past(i_fetch && i_pm_data_busy))
    else $error("stall without conflict");
  miss_fill_a: assert property (miss_s |=> o_instr_valid && !o_stall)
    else $error("no instruction after miss");
  hit_or_miss_a: assert property (conflict_s |=> o_stall != o_instr_valid)
    else $error("conflict fetch gave neither hit nor miss");
  free_fetch_a: assert property (i_fetch && !i_pm_data_busy |=> o_instr_valid && !o_stall)
    else $error("free fetch not answered");
  valid_cause_a: assert property (o_instr_valid |-> $past(i_fetch) || $past(o_stall))
    else $error("instruction valid without fetch");
endmodule
bind simd_datapath simd_properties props (.i_core_clk, .i_rst, .i_mode_we, .i_mode_wdata, .i_issue,
  .i_fetch, .i_pm_data_busy, .o_mode, .o_dm_wdata, .o_result_x, .o_result_y, .o_instr_valid, .o_stall);
